// [core/sap_adc_end.sv]
// Purpose: Converter end of the serial port: config, sample, convert.
// Assumes: Host keeps its side of the frame; link pins are asynchronous.
// Notes: Analog levels arrive as unsigned codes on channel_level_i.
// Summary of operation
// - Frame starts only with select low
// - Select high aborts, enters standby
// - Host raises select between conversions
// - Config bits taken on rising clock
// - Output changes only on falling clock
// - Serial clock paces whole conversion
// - Both inputs sampled for 1.5 cycles
// - Thirteen conversion cycles follow sampling
// - Host gives at least thirteen cycles
// - Result is 13-bit two's complement
// - Sign bit goes out first
// - Codes saturate at 0x1000 and 0x0FFF
// - Single-ended mode reads minus side as zero
// - Slower clock lengthens sampling
// - Sign is one when negative higher
// - Keep clock above 105 kHz converting
`timescale 1ns/1ps
module sap_adc_end (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Serial link
  sap_link_if.adc link,
  // Analog levels and status
  input wire sap_pkg::sap_levels_t channel_level_i,
  output logic standby_o,
  output logic sampling_o,
  output logic [sap_pkg::CFG_W-1:0] config_o,
  output logic [sap_pkg::RES_W-1:0] code_o
);
  import sap_pkg::*;

  typedef enum logic [2:0] {
    ST_STANDBY,
    ST_START,
    ST_CONFIG,
    ST_SAMPLE,
    ST_CONVERT,
    ST_DONE
  } sap_adc_state_t;

  sap_adc_state_t state_q;
  sap_adc_state_t state_d;
  logic sel_s1_q;
  logic sel_s2_q;
  logic sclk_s1_q;
  logic sclk_s2_q;
  logic sclk_s3_q;
  logic din_s1_q;
  logic din_s2_q;
  logic selected;
  logic rise;
  logic fall;
  logic [1:0] cfg_cnt_q;
  logic [CFG_W-1:0] cfg_q;
  logic win_cnt_q;
  logic [3:0] bit_idx_q;
  logic [RES_W-1:0] code_q;
  logic [LEVEL_W-1:0] pos_hold_q;
  logic [LEVEL_W-1:0] neg_hold_q;
  logic dout_q;
  logic oe_q;
  logic sample_end;

  // Pick the level for one side of the input pair
  function automatic logic [LEVEL_W-1:0] route_level(
    input logic [CFG_W-1:0] cfg,
    input sap_levels_t lv,
    input logic positive
  );
    logic [CH_W-1:0] ch;
    ch = cfg[CFG_CH_LSB +: CH_W];
    if (cfg[CFG_SGL_BIT])
      route_level = positive ? lv[ch] : '0;
    else
      route_level = lv[{ch[CH_W-1:1], ch[0] ^ ~positive}];
  endfunction

  // Difference of the pair, clipped to the signed code range
  function automatic logic [RES_W-1:0] sat_code(
    input logic [LEVEL_W-1:0] pos,
    input logic [LEVEL_W-1:0] neg
  );
    logic signed [LEVEL_W:0] diff;
    diff = $signed({1'b0, pos}) - $signed({1'b0, neg});
    if (diff > $signed({1'b0, CODE_MAX}))
      sat_code = CODE_MAX;
    else if (diff < $signed({1'b1, CODE_MIN}))
      sat_code = CODE_MIN;
    else
      sat_code = diff[RES_W-1:0];
  endfunction

  // Two stages on every link input before any logic looks at them
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sel_s1_q <= 1'b1;
      sel_s2_q <= 1'b1;
      sclk_s1_q <= 1'b0;
      sclk_s2_q <= 1'b0;
      sclk_s3_q <= 1'b0;
      din_s1_q <= 1'b0;
      din_s2_q <= 1'b0;
    end
    else
    begin
      sel_s1_q <= link.select_and_sleep_n;
      sel_s2_q <= sel_s1_q;
      sclk_s1_q <= link.sclk;
      sclk_s2_q <= sclk_s1_q;
      sclk_s3_q <= sclk_s2_q;
      din_s1_q <= link.host_to_adc_serial;
      din_s2_q <= din_s1_q;
    end
  end

  // Edges of the host clock; nothing runs without them
  assign selected = ~sel_s2_q;
  assign rise = sclk_s2_q & ~sclk_s3_q;
  assign fall = ~sclk_s2_q & sclk_s3_q;
  assign sample_end = (state_q == ST_SAMPLE) && fall
                      && (win_cnt_q == 1'(SAMPLE_FALLS - 1));

  // Frame sequence
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_STANDBY:
        if (selected)
          state_d = ST_START;
      ST_START:
        if (rise && din_s2_q)
          state_d = ST_CONFIG;
      ST_CONFIG:
        if (rise && cfg_cnt_q == 2'(CFG_W - 1))
          state_d = ST_SAMPLE;
      ST_SAMPLE:
        if (sample_end)
          state_d = ST_CONVERT;
      ST_CONVERT:
        if (fall && bit_idx_q == 4'h0)
          state_d = ST_DONE;
      ST_DONE:
        state_d = ST_DONE;
      default:
        state_d = ST_STANDBY;
    endcase
    // Deselect wins over every other step
    if (!selected)
      state_d = ST_STANDBY;
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state_q <= ST_STANDBY;
    else
      state_q <= state_d;
  end

  // Configuration shift, taken on rising edges only
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cfg_cnt_q <= 2'h0;
      cfg_q <= CFG_RST;
    end
    else if (state_q == ST_START)
      cfg_cnt_q <= 2'h0;
    else if (state_q == ST_CONFIG && rise)
    begin
      cfg_cnt_q <= cfg_cnt_q + 2'h1;
      cfg_q <= {cfg_q[CFG_W-2:0], din_s2_q};
    end
  end

  // Sampling window: from the last config rise to the second fall
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      win_cnt_q <= 1'b0;
    else if (state_q != ST_SAMPLE)
      win_cnt_q <= 1'b0;
    else if (fall)
      win_cnt_q <= ~win_cnt_q;
  end

  // Both sides captured in one clock, so common mode cancels
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pos_hold_q <= '0;
      neg_hold_q <= '0;
    end
    else if (sample_end)
    begin
      pos_hold_q <= route_level(cfg_q, channel_level_i, 1'b1);
      neg_hold_q <= route_level(cfg_q, channel_level_i, 1'b0);
    end
  end

  // Code resolved from the held pair well before the sign goes out
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      code_q <= CODE_RST;
    else if (state_q == ST_CONVERT && bit_idx_q == 4'(RES_W - 1))
      code_q <= sat_code(pos_hold_q, neg_hold_q);
  end

  // Bit index walks from the sign bit down, one per falling edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      bit_idx_q <= 4'(RES_W - 1);
    else if (state_q != ST_CONVERT)
      bit_idx_q <= 4'(RES_W - 1);
    else if (fall && bit_idx_q != 4'h0)
      bit_idx_q <= bit_idx_q - 4'h1;
  end

  // Serial output: a leading zero at hold, then the code MSB first
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dout_q <= 1'b0;
    else if (!selected)
      dout_q <= 1'b0;
    else if (sample_end)
      dout_q <= 1'b0;
    else if (state_q == ST_CONVERT && fall)
      dout_q <= code_q[bit_idx_q];
    else if (state_q == ST_DONE && fall)
      dout_q <= 1'b0;
  end

  // Output released in standby so the line can be shared
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      oe_q <= 1'b0;
    else if (!selected)
      oe_q <= 1'b0;
    else if (sample_end)
      oe_q <= 1'b1;
  end

  // Pins and user status
  assign link.adc_serial_out = dout_q;
  assign link.adc_serial_oe = oe_q;
  assign standby_o = (state_q == ST_STANDBY);
  assign sampling_o = (state_q == ST_SAMPLE);
  assign config_o = cfg_q;
  assign code_o = code_q;
endmodule // sap_adc_end

// [core/sap_fifo.sv]
// Purpose: Result buffer with valid and ready on both sides.
// Assumes: One clock domain.
// Notes: Read data is the memory word at the read pointer.
`timescale 1ns/1ps
module sap_fifo #(
  parameter int W = 17,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Filling side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  // Draining side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wptr_q;
  logic [AW:0] rptr_q;
  logic push;
  logic pop;

  // Full when pointers differ only in the wrap bit
  assign in_ready_o = (wptr_q ^ rptr_q) != {1'b1, {AW{1'b0}}};
  assign out_valid_o = wptr_q != rptr_q;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem[rptr_q[AW-1:0]];

  // Storage, no reset needed for data
  always_ff @(posedge clk_i)
  begin
    if (push)
      mem[wptr_q[AW-1:0]] <= in_data_i;
  end

  // Pointers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wptr_q <= '0;
      rptr_q <= '0;
    end
    else
    begin
      if (push)
        wptr_q <= wptr_q + 1'b1;
      if (pop)
        rptr_q <= rptr_q + 1'b1;
    end
  end
endmodule // sap_fifo

// [core/sap_host_end.sv]
// Purpose: Host end: runs one conversion frame per request.
// Assumes: Converter answers within a half period of the serial clock.
// Notes: Serial clock comes from a divider of the system clock.
`timescale 1ns/1ps
module sap_host_end (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Conversion request
  input wire logic start_i,
  input wire logic [sap_pkg::CFG_W-1:0] config_i,
  output logic busy_o,
  // Results, configuration word above the code
  output logic result_valid_o,
  input wire logic result_ready_i,
  output logic [sap_pkg::FIFO_W-1:0] result_data_o,
  // Serial link
  sap_link_if.host link
);
  import sap_pkg::*;

  typedef enum logic [1:0] {
    H_IDLE,
    H_LEAD,
    H_RUN,
    H_GAP
  } sap_host_state_t;

  sap_host_state_t state_q;
  logic [3:0] hc_q;
  logic tick;
  logic sclk_q;
  logic sel_n_q;
  logic [4:0] rise_cnt_q;
  logic [CFG_W:0] tx_q;
  logic [CFG_W-1:0] cfg_hold_q;
  logic [RES_W-1:0] rx_q;
  logic push_q;
  logic fifo_ready;
  logic miso_s1_q;
  logic miso_s2_q;

  // Half period divider; a slower clock lengthens sampling
  assign tick = (hc_q == 4'(SCLK_HALF_CYC - 1));
  always_ff @(posedge clk_i)
  begin
    if (rst_i || state_q == H_IDLE || tick)
      hc_q <= 4'h0;
    else
      hc_q <= hc_q + 4'h1;
  end

  // Returned data is asynchronous to this clock
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      miso_s1_q <= 1'b0;
      miso_s2_q <= 1'b0;
    end
    else
    begin
      miso_s1_q <= link.adc_to_host_serial;
      miso_s2_q <= miso_s1_q;
    end
  end

  // Frame sequence and pins; a full buffer holds off new frames
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= H_IDLE;
      sel_n_q <= 1'b1;
      sclk_q <= 1'b0;
      rise_cnt_q <= 5'h0;
      tx_q <= '0;
      cfg_hold_q <= CFG_RST;
    end
    else
    begin
      case (state_q)
        H_IDLE:
          if (start_i && fifo_ready)
          begin
            state_q <= H_LEAD;
            sel_n_q <= 1'b0;
            tx_q <= {1'b1, config_i};
            cfg_hold_q <= config_i;
            rise_cnt_q <= 5'h0;
          end
        H_LEAD:
          if (tick)
          begin
            state_q <= H_RUN;
            sclk_q <= 1'b1;
            rise_cnt_q <= 5'h1;
          end
        H_RUN:
          if (tick && sclk_q)
          begin
            sclk_q <= 1'b0;
            tx_q <= {tx_q[CFG_W-1:0], 1'b0};
            if (rise_cnt_q == 5'(FRAME_RISES))
              state_q <= H_GAP;
          end
          else if (tick)
          begin
            sclk_q <= 1'b1;
            rise_cnt_q <= rise_cnt_q + 5'h1;
          end
        H_GAP:
        begin
          sel_n_q <= 1'b1;
          if (tick)
            state_q <= H_IDLE;
        end
        default:
          state_q <= H_IDLE;
      endcase
    end
  end

  // Result bits taken at rises after the leading zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rx_q <= CODE_RST;
    else if (state_q == H_RUN && tick && !sclk_q
             && rise_cnt_q >= 5'(FIRST_DATA_RISE - 1))
      rx_q <= {rx_q[RES_W-2:0], miso_s2_q};
  end

  // One push per frame, held until the buffer takes it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      push_q <= 1'b0;
    else if (state_q == H_RUN && tick && sclk_q
             && rise_cnt_q == 5'(FRAME_RISES))
      push_q <= 1'b1;
    else if (fifo_ready)
      push_q <= 1'b0;
  end

  sap_fifo #(
    .W(FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(push_q),
    .in_ready_o(fifo_ready),
    .in_data_i({cfg_hold_q, rx_q}),
    .out_valid_o(result_valid_o),
    .out_ready_i(result_ready_i),
    .out_data_o(result_data_o)
  );

  // Pins straight from flops
  assign link.select_and_sleep_n = sel_n_q;
  assign link.sclk = sclk_q;
  assign link.host_to_adc_serial = tx_q[CFG_W];
  assign busy_o = (state_q != H_IDLE) || push_q;
endmodule // sap_host_end

// [core/sap_link_if.sv]
// Purpose: Serial link between the host end and the converter end.
// Assumes: Converter output is pulled low while not driven.
// Notes: The only shared wire level is resolved here from the enable.
`timescale 1ns/1ps
interface sap_link_if;
  logic select_and_sleep_n;
  logic sclk;
  logic host_to_adc_serial;
  logic adc_serial_out;
  logic adc_serial_oe;
  logic adc_to_host_serial;

  // Undriven output reads as a weak low
  assign adc_to_host_serial = adc_serial_oe ? adc_serial_out : 1'b0;

  modport adc (
    input select_and_sleep_n,
    input sclk,
    input host_to_adc_serial,
    output adc_serial_out,
    output adc_serial_oe
  );

  modport host (
    output select_and_sleep_n,
    output sclk,
    output host_to_adc_serial,
    input adc_to_host_serial
  );
endinterface

// [core/sap_pkg.sv]
// Purpose: Shared constants and types of the serial converter port.
// Assumes: System clock of 100 MHz on both ends.
// Notes: Configuration word is sent as start bit, mode bit, channel.
package sap_pkg;

  // System clock and serial clock timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCLK_HALF_NS = 80;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  // Lowest serial clock rate advised while converting
  localparam int MIN_SCLK_KHZ = 105;

  // Word widths
  localparam int RES_W = 13;
  localparam int CFG_W = 4;
  localparam int CH_N = 8;
  localparam int CH_W = 3;
  localparam int LEVEL_W = 13;

  // Configuration word fields: mode bit then channel number
  localparam int CFG_SGL_BIT = 3;
  localparam int CFG_CH_LSB = 0;

  // Frame shape, counted in serial clock edges
  localparam int SAMPLE_FALLS = 2;
  localparam int FRAME_RISES = 20;
  localparam int FIRST_DATA_RISE = FRAME_RISES - RES_W + 1;

  // Result code limits
  localparam logic [RES_W-1:0] CODE_MAX = 13'h0FFF;
  localparam logic [RES_W-1:0] CODE_MIN = 13'h1000;

  // Result FIFO on the host side
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_W = CFG_W + RES_W;

  // Reset values
  localparam logic [RES_W-1:0] CODE_RST = 13'h0000;
  localparam logic [CFG_W-1:0] CFG_RST = 4'h0;

  typedef logic [CH_N-1:0][LEVEL_W-1:0] sap_levels_t;

endpackage

// [test/sap_link_chk.sv]
// Purpose: Timing checks on the serial link between the two ends.
// Assumes: Both ends share clk_i; rst_i is synchronous, active high.
// Notes: Rise counter restarts whenever select is high.
`timescale 1ns/1ps
module sap_link_chk (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Link signals
  input wire logic select_and_sleep_n,
  input wire logic sclk,
  input wire logic host_to_adc_serial,
  input wire logic adc_serial_out,
  input wire logic adc_serial_oe,
  input wire logic adc_to_host_serial
);
  import sap_pkg::*;
  logic sclk_q;
  logic [4:0] rise_cnt_q;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Previous serial clock level for edge finding
  always_ff @(posedge clk_i)
  begin
    sclk_q <= rst_i ? 1'b0 : sclk;
  end

  // Rises within the current frame; idle select clears it
  always_ff @(posedge clk_i)
  begin
    if (rst_i || select_and_sleep_n)
      rise_cnt_q <= 5'h0;
    else if (sclk && !sclk_q)
      rise_cnt_q <= rise_cnt_q + 5'h1;
  end

  a_idle_quiet: assert property (select_and_sleep_n [*6] |->
    !adc_serial_oe && !sclk) else $error("link active while deselected");
  a_abort_release: assert property ($rose(select_and_sleep_n) |->
    ##[1:5] !adc_serial_oe) else $error("output kept after deselect");
  a_cfg_bit_hold: assert property ($rose(sclk) |->
    $stable(host_to_adc_serial) [*7]) else $error("data moved near rise");
  a_out_on_fall: assert property ($changed(adc_serial_out) &&
    adc_serial_oe && !select_and_sleep_n |-> !sclk)
    else $error("result bit changed while clock high");
  a_sclk_half: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
    else $error("serial clock high phase not eight cycles");
  a_no_early_drive: assert property (!select_and_sleep_n &&
    rise_cnt_q < 5'h6 |-> !adc_serial_oe)
    else $error("output driven before sampling ends");
  a_drive_start: assert property ($rose(adc_serial_oe) |->
    rise_cnt_q == 5'h6) else $error("output enabled at wrong rise");
  a_frame_rises: assert property ($rose(select_and_sleep_n) |->
    rise_cnt_q == 5'(FRAME_RISES)) else $error("wrong rise count");
  a_drive_bits: assert property (!select_and_sleep_n &&
    rise_cnt_q > 5'h6 && rise_cnt_q < 5'h14 |-> adc_serial_oe)
    else $error("output released during result");
  a_null_lead: assert property ($rose(sclk) && rise_cnt_q == 5'h6
    |-> adc_serial_oe && !adc_to_host_serial)
    else $error("bit before sign not zero");

  c_frame: cover property ($rose(select_and_sleep_n) && rise_cnt_q == 5'h14);
  c_drive: cover property ($rose(adc_serial_oe));
  c_select: cover property ($fell(select_and_sleep_n));
endmodule // sap_link_chk

// [test/tb_top.sv]
// Purpose: Self-checking bench of host end and converter end.
// Assumes: Second link is driven by the bench as a misbehaving host.
// Notes: Expected codes come from channel levels and config word.
`timescale 1ns/1ps
module tb_top;
  import sap_pkg::*;
  localparam sap_levels_t LV_B = {13'h0000, 13'h1000, 13'h0000, 13'h0FFF,
    13'h004D, 13'h004D, 13'h1FFF, 13'h0000};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic start = 1'b0;
  logic [CFG_W-1:0] cfg = CFG_RST;
  logic ready = 1'b0;
  logic busy;
  logic rvalid;
  logic [FIFO_W-1:0] rdata;
  sap_levels_t lv = '0;
  logic stby;
  logic stby2;
  logic samp;
  logic [CFG_W-1:0] cfg_a;
  logic [CFG_W-1:0] cfg_b;
  logic [RES_W-1:0] code_a;
  logic [RES_W-1:0] code_b;
  logic [RES_W-1:0] e;
  logic sclk_q = 1'b0;
  logic [19:0] mosi_sh = '0;
  logic [19:0] miso_sh = '0;
  int n_mismatch = 0;
  int comparisons = 0;
  int cyc = 0;
  int samp_n = 0;

  sap_link_if link ();
  sap_link_if lk2 ();
  sap_host_end i_sap_host_end (.clk_i(clk_i), .rst_i(rst_i),
    .start_i(start), .config_i(cfg), .busy_o(busy),
    .result_valid_o(rvalid), .result_ready_i(ready),
    .result_data_o(rdata), .link(link));
  sap_adc_end i_sap_adc_end (.clk_i(clk_i), .rst_i(rst_i), .link(link),
    .channel_level_i(lv), .standby_o(stby), .sampling_o(samp),
    .config_o(cfg_a), .code_o(code_a));
  sap_adc_end i_sap_adc_end_2 (.clk_i(clk_i), .rst_i(rst_i), .link(lk2),
    .channel_level_i(lv), .standby_o(stby2), .sampling_o(),
    .config_o(cfg_b), .code_o(code_b));
  sap_link_chk i_sap_link_chk (.clk_i(clk_i), .rst_i(rst_i),
    .select_and_sleep_n(link.select_and_sleep_n), .sclk(link.sclk),
    .host_to_adc_serial(link.host_to_adc_serial),
    .adc_serial_out(link.adc_serial_out),
    .adc_serial_oe(link.adc_serial_oe),
    .adc_to_host_serial(link.adc_to_host_serial));

  // Clock
  always #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;

  // Wire bits at each rise; last 20 rises hold a frame
  always @(posedge clk_i)
  begin
    sclk_q <= link.sclk;
    if (link.sclk && !sclk_q)
    begin
      mosi_sh <= {mosi_sh[18:0], link.host_to_adc_serial};
      miso_sh <= {miso_sh[18:0], link.adc_to_host_serial};
    end
  end

  // Cycles in the last sampling window; a new request clears it
  always @(posedge clk_i)
  begin
    if (start)
      samp_n <= 0;
    else if (samp === 1'b1)
      samp_n <= samp_n + 1;
  end

  // Hang guard, well above the expected run length
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_mismatch++;
      conclude();
    end
  end

  task tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task check(input string what, input logic [FIFO_W-1:0] seen,
    input logic [FIFO_W-1:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task conclude();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Saturated difference; single-ended mode reads the minus side as zero
  function automatic logic [RES_W-1:0] exp_code(input logic [3:0] c);
    int p;
    int n;
    int d;
    p = lv[c[2:0]];
    n = c[3] ? 0 : lv[{c[2:1], ~c[0]}];
    d = p - n;
    if (d > 4095)
      d = 4095;
    if (d < -4096)
      d = -4096;
    return d[12:0];
  endfunction

  // One frame request; start held as a level until busy rises
  task convert(input logic [3:0] c);
    int k;
    cfg = c;
    start = 1'b1;
    k = 0;
    do
    begin
      tick(1);
      k++;
    end while (busy !== 1'b1 && k < 30);
    start = 1'b0;
    k = 0;
    while (busy === 1'b1 && k < 800)
    begin
      tick(1);
      k++;
    end
    check("busy_end", FIFO_W'(busy), '0);
  endtask

  task pop(input logic [3:0] c, input logic [RES_W-1:0] x);
    int k;
    k = 0;
    while (rvalid !== 1'b1 && k < 800)
    begin
      tick(1);
      k++;
    end
    check("result", rdata, {c, x});
    ready = 1'b1;
    tick(1);
    ready = 1'b0;
    tick(1);
  endtask

  // Bench as host of the second link; config word sent on falls
  task frame2(input logic [4:0] bits, input int n);
    for (int i = 0; i < n; i++)
    begin
      lk2.host_to_adc_serial = (i < 5) ? bits[4 - i] : 1'b0;
      tick(8);
      lk2.sclk = 1'b1;
      tick(8);
      lk2.sclk = 1'b0;
    end
  endtask

  task set_a();
    for (int k = 0; k < CH_N; k++)
      lv[k] = 13'(k * 1000 + 123);
  endtask

  // Main sequence
  initial
  begin
    lk2.select_and_sleep_n = 1'b1;
    lk2.sclk = 1'b0;
    lk2.host_to_adc_serial = 1'b0;
    tick(12);
    rst_i = 1'b0;
    check("reset_code", FIFO_W'(code_a), FIFO_W'(CODE_RST));
    for (int s = 0; s < 2; s++)
    begin
      set_a();
      if (s == 1)
        lv = LV_B;
      for (int c = 0; c < 16; c++)
      begin
        e = exp_code(4'(c));
        convert(4'(c));
        check("config", FIFO_W'(cfg_a), FIFO_W'(c));
        check("code", FIFO_W'(code_a), FIFO_W'(e));
        check("wire_cfg", FIFO_W'(mosi_sh[19:15]),
          FIFO_W'({1'b1, 4'(c)}));
        check("sample_len", FIFO_W'(samp_n),
          FIFO_W'(3 * SCLK_HALF_CYC));
        check("wire_res", FIFO_W'(miso_sh[13:0]), FIFO_W'({1'b0, e}));
        check("standby", FIFO_W'(stby), FIFO_W'(1'b1));
        pop(4'(c), e);
      end
    end
    $display("test codes done");
    set_a();
    for (int c = 0; c < FIFO_DEPTH; c++)
      convert(4'(c));
    start = 1'b1;
    tick(40);
    check("full_refused", FIFO_W'(busy), '0);
    start = 1'b0;
    for (int c = 0; c < FIFO_DEPTH; c++)
      pop(4'(c), exp_code(4'(c)));
    check("drained", FIFO_W'(rvalid), '0);
    $display("test buffer done");
    frame2(5'h1D, 20);
    check("ignored_cfg", FIFO_W'(cfg_b), FIFO_W'(CFG_RST));
    lk2.select_and_sleep_n = 1'b0;
    frame2(5'h1C, 10);
    lk2.select_and_sleep_n = 1'b1;
    tick(6);
    check("abort_oe", FIFO_W'(lk2.adc_serial_oe), '0);
    check("abort_standby", FIFO_W'(stby2), FIFO_W'(1'b1));
    check("abort_cfg", FIFO_W'(cfg_b), FIFO_W'(4'hC));
    tick(8);
    lk2.select_and_sleep_n = 1'b0;
    frame2(5'h1C, 20);
    e = exp_code(4'hC);
    check("link2_code", FIFO_W'(code_b), FIFO_W'(e));
    lv = LV_B;
    frame2(5'h1C, 20);
    check("held_low_code", FIFO_W'(code_b), FIFO_W'(e));
    lk2.select_and_sleep_n = 1'b1;
    $display("test link2 done");
    conclude();
  end
endmodule // tb_top
